// >>> rtl/ucc_pkg.sv
`default_nettype none
package ucc_pkg;
  // serial (byte) addresses
  localparam logic [7:0] ADDR_PAGE = 8'hff;
  // full register addresses inside the paged spaces
  localparam logic [15:0] ADDR_CTRL1 = 16'h6100;
  localparam logic [15:0] ADDR_RUN = 16'h6102;
  localparam logic [15:0] ADDR_DET = 16'h6103;
  // page select codes and the high address byte they open
  localparam logic [2:0] PAGE_3000 = 3'h0;
  localparam logic [2:0] PAGE_3100 = 3'h2;
  localparam logic [2:0] PAGE_6100 = 3'h6;
  localparam logic [7:0] BASE_3000 = 8'h30;
  localparam logic [7:0] BASE_3100 = 8'h31;
  localparam logic [7:0] BASE_6100 = 8'h61;
  localparam int PAGE_LSB = 5;
  // reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_RUN = 8'h00;
  localparam logic [7:0] RST_DET = 8'h00;
  // run-time control fields
  localparam int RUN_SUSPEND = 6;
  localparam int RUN_RESET = 5;
  localparam int RUN_OE = 4;
  localparam int RUN_DP_PD = 3;
  localparam int RUN_DM_PD = 2;
  localparam int RUN_SPEED_LSB = 0;
  localparam logic [7:0] RUN_WR_MASK = 8'h7f;
  // detect register fields
  localparam int DET_EN = 2;
  localparam int DET_OUT = 1;
  localparam int DET_BIAS = 0;
  localparam logic [7:0] DET_WR_MASK = 8'h05;
  // first charging control register fields
  localparam int CTRL1_SRC = 6;
  localparam int CTRL1_SINK = 4;
  localparam int CTRL1_VDET = 3;
  localparam logic [7:0] CTRL1_WR_MASK = 8'hf7;
  // transceiver speed codes
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_LS = 2'h2;
  localparam logic [1:0] SPEED_LS_FSEDGE = 2'h3;

  // {valid, high address byte} for a page code
  function automatic logic [8:0] page_base(input logic [2:0] pg);
    case (pg)
      PAGE_3000: page_base = {1'b1, BASE_3000};
      PAGE_3100: page_base = {1'b1, BASE_3100};
      PAGE_6100: page_base = {1'b1, BASE_6100};
      default: page_base = 9'h000;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> rtl/ucc_regacc_if.sv
`default_nettype none
interface ucc_regacc_if;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [2:0] page;
  logic page_ok;
  logic hit_page;
  logic hit_ctrl1;
  logic hit_run;
  logic hit_det;
  modport dec (output wr, rd, wdata, page, page_ok, hit_page, hit_ctrl1, hit_run, hit_det);
  modport core (input wr, rd, wdata, page, page_ok, hit_page, hit_ctrl1, hit_run, hit_det);
endinterface
`default_nettype wire

// >>> rtl/ucc_page_dec.sv
`default_nettype none
module ucc_page_dec (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial register access
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  // decoded access
  ucc_regacc_if.dec acc
);
  logic [2:0] page_r;
  logic [2:0] page_nxt;
  logic [8:0] base;
  logic [15:0] full_addr;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    base = ucc_pkg::page_base(page_r);
    full_addr = {base[7:0], addr_i};
    page_nxt = page_r;
    // reserved low bits are dropped, never stored
    if (wr_i && addr_i == ucc_pkg::ADDR_PAGE) begin
      page_nxt = wdata_i[7:ucc_pkg::PAGE_LSB];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_r <= ucc_pkg::RST_PAGE[7:ucc_pkg::PAGE_LSB];
    end else begin
      page_r <= page_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlisted page opens nothing below the page register
  always_comb begin
    acc.wr = wr_i;
    acc.rd = rd_i;
    acc.wdata = wdata_i;
    acc.page = page_r;
    acc.page_ok = base[8];
    acc.hit_page = addr_i == ucc_pkg::ADDR_PAGE;
    acc.hit_ctrl1 = !acc.hit_page && base[8] && full_addr == ucc_pkg::ADDR_CTRL1;
    acc.hit_run = !acc.hit_page && base[8] && full_addr == ucc_pkg::ADDR_RUN;
    acc.hit_det = !acc.hit_page && base[8] && full_addr == ucc_pkg::ADDR_DET;
  end
endmodule // ucc_page_dec
`default_nettype wire

// >>> rtl/ucc_hicur_det.sv
`default_nettype none
module ucc_hicur_det (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // detector
  input wire logic en_i,
  input wire logic raw_i,
  output logic det_o
);
  logic det_r;
  logic det_nxt;

  ////////////////////////////////////////////////////////////////////////
  // comparator sampled only while enabled; idle detector reads low
  always_comb begin
    det_nxt = en_i & raw_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      det_r <= 1'b0;
    end else begin
      det_r <= det_nxt;
    end
  end

  // gate again so a disable is seen in the same cycle
  assign det_o = det_r & en_i;
endmodule // ucc_hicur_det
`default_nettype wire

// >>> rtl/ucc_upstream_regs.sv
// Behaviour
// - run-time bit 6 set forces the upstream port into suspend.
// - run-time bit 5 set holds the upstream port in reset.
// - run-time bit 4 set forces the full-speed output enable on.
// - run-time bit 3 connects the positive data line pull-down.
// - run-time bit 2 connects the negative data line pull-down.
// - bits 1:0 pick HS, FS, LS, or LS rate with FS edges.
// - detect bit 2 enables the high-current charger detector.
// - detect bit 1 is read-only result, zero while detector disabled.
// - page bits 7:5 select 3000, 3100 or 6100 register space.
// - control-1 bit 4 enables data current sink and its comparator.
`default_nettype none
module ucc_upstream_regs (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial register access
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // analog status
  input wire logic hi_current_raw_i,
  input wire logic vdat_det_i,
  // upstream port forcing
  output logic force_suspend_o,
  output logic force_reset_o,
  output logic force_output_enable_o,
  output logic dp_pulldown_en_o,
  output logic dm_pulldown_en_o,
  output logic [1:0] transceiver_speed_sel_o,
  // charger analog controls
  output logic hi_current_detect_en_o,
  output logic charge_bias_en_o,
  output logic [7:0] charge_ctrl1_o,
  output logic data_sink_en_o,
  output logic data_src_en_o
);
  ucc_regacc_if acc ();

  logic [6:0] run_r;
  logic [6:0] run_nxt;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl1_nxt;
  logic det_en_r;
  logic det_en_nxt;
  logic bias_r;
  logic bias_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic hi_det;

  ////////////////////////////////////////////////////////////////////////
  ucc_page_dec u_dec (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(reg_addr_i),
    .wr_i(reg_wr_i),
    .rd_i(reg_rd_i),
    .wdata_i(reg_wdata_i),
    .acc(acc)
  );

  ucc_hicur_det u_hicur (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(det_en_r),
    .raw_i(hi_current_raw_i),
    .det_o(hi_det)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are masked away
  always_comb begin
    run_nxt = run_r;
    ctrl1_nxt = ctrl1_r;
    det_en_nxt = det_en_r;
    bias_nxt = bias_r;
    if (acc.wr && acc.hit_run) begin
      run_nxt = reg_wdata_i[6:0] & ucc_pkg::RUN_WR_MASK[6:0];
    end
    if (acc.wr && acc.hit_ctrl1) begin
      ctrl1_nxt = reg_wdata_i & ucc_pkg::CTRL1_WR_MASK;
    end
    if (acc.wr && acc.hit_det) begin
      det_en_nxt = reg_wdata_i[ucc_pkg::DET_EN];
      bias_nxt = reg_wdata_i[ucc_pkg::DET_BIAS];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= ucc_pkg::RST_RUN[6:0];
      ctrl1_r <= ucc_pkg::RST_CTRL1;
      det_en_r <= ucc_pkg::RST_DET[ucc_pkg::DET_EN];
      bias_r <= ucc_pkg::RST_DET[ucc_pkg::DET_BIAS];
    end else begin
      run_r <= run_nxt;
      ctrl1_r <= ctrl1_nxt;
      det_en_r <= det_en_nxt;
      bias_r <= bias_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; every access is acked, unmapped reads give zero
  always_comb begin
    rdata_nxt = 8'h00;
    ack_nxt = acc.wr | acc.rd;
    if (acc.rd) begin
      if (acc.hit_page) begin
        rdata_nxt = {acc.page, 5'h00};
      end else if (acc.hit_run) begin
        rdata_nxt = {1'b0, run_r};
      end else if (acc.hit_det) begin
        rdata_nxt = {5'h00, det_en_r, hi_det, bias_r};
      end else if (acc.hit_ctrl1) begin
        rdata_nxt = ctrl1_r;
        rdata_nxt[ucc_pkg::CTRL1_VDET] = vdat_det_i;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the register flops; the speed field is not
  // guarded against live traffic, the master keeps it still
  assign reg_rdata_o = rdata_r;
  assign reg_ack_o = ack_r;
  assign force_suspend_o = run_r[ucc_pkg::RUN_SUSPEND];
  assign force_reset_o = run_r[ucc_pkg::RUN_RESET];
  assign force_output_enable_o = run_r[ucc_pkg::RUN_OE];
  assign dp_pulldown_en_o = run_r[ucc_pkg::RUN_DP_PD];
  assign dm_pulldown_en_o = run_r[ucc_pkg::RUN_DM_PD];
  assign transceiver_speed_sel_o = run_r[ucc_pkg::RUN_SPEED_LSB +: 2];
  assign hi_current_detect_en_o = det_en_r;
  // bias is not forced on with sink/source: software owns that pairing
  assign charge_bias_en_o = bias_r;
  assign charge_ctrl1_o = ctrl1_r;
  assign data_sink_en_o = ctrl1_r[ucc_pkg::CTRL1_SINK];
  assign data_src_en_o = ctrl1_r[ucc_pkg::CTRL1_SRC];

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_run_write;
    acc.wr && acc.hit_run;
  endsequence

  sequence s_det_write;
    acc.wr && acc.hit_det;
  endsequence

  sequence s_strobe;
    acc.wr || acc.rd;
  endsequence

  sequence s_det_read;
    acc.rd && acc.hit_det;
  endsequence

  sequence s_ctrl1_write;
    acc.wr && acc.hit_ctrl1;
  endsequence

  sequence s_page_write;
    acc.wr && acc.hit_page;
  endsequence

  property p_suspend;
    s_run_write |=> force_suspend_o == $past(reg_wdata_i[6]);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend force wrong");

  property p_reset;
    s_run_write |=> force_reset_o == $past(reg_wdata_i[5]);
  endproperty
  a_reset: assert property (p_reset) else $error("reset force wrong");

  property p_oe;
    s_run_write |=> force_output_enable_o == $past(reg_wdata_i[4]);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable force wrong");

  property p_pulldowns;
    s_run_write |=> {dp_pulldown_en_o, dm_pulldown_en_o} == $past(reg_wdata_i[3:2]);
  endproperty
  a_pulldowns: assert property (p_pulldowns) else $error("pull-down wrong");

  property p_speed_hold;
    !(acc.wr && acc.hit_run) |=> $stable(transceiver_speed_sel_o);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed moved without write");

  property p_speed_set;
    s_run_write |=> transceiver_speed_sel_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_speed_set: assert property (p_speed_set) else $error("speed select wrong");

  property p_det_en;
    s_det_write |=> hi_current_detect_en_o == $past(reg_wdata_i[2]);
  endproperty
  a_det_en: assert property (p_det_en) else $error("detector enable wrong");

  property p_det_off_zero;
    (acc.rd && acc.hit_det && !det_en_r) |=> reg_ack_o && !reg_rdata_o[1];
  endproperty
  a_det_off_zero: assert property (p_det_off_zero) else $error("detect bit set while off");

  property p_bad_page;
    (acc.wr && !acc.hit_page && !acc.page_ok) |=> $stable(run_r) && $stable(det_en_r)
      && $stable(ctrl1_r);
  endproperty
  a_bad_page: assert property (p_bad_page) else $error("unlisted page wrote register");

  property p_page_space;
    acc.hit_run |-> acc.page == ucc_pkg::PAGE_6100 && reg_addr_i == 8'h02;
  endproperty
  a_page_space: assert property (p_page_space) else $error("run register decoded off page");

  property p_sink;
    s_ctrl1_write |=> data_sink_en_o == $past(reg_wdata_i[4]);
  endproperty
  a_sink: assert property (p_sink) else $error("data sink enable wrong");

  property p_reserved;
    acc.rd && acc.hit_run |=> reg_ack_o && !reg_rdata_o[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit read as one");

  property p_page_reserved;
    acc.rd && acc.hit_page |=> reg_rdata_o[4:0] == 5'h00;
  endproperty
  a_page_reserved: assert property (p_page_reserved) else $error("page low bits set");

  property p_det_reserved;
    s_det_read |=> reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_det_reserved: assert property (p_det_reserved) else $error("detect high bits set");

  property p_run_read;
    acc.rd && acc.hit_run |=> reg_rdata_o[6:0] == $past(run_r);
  endproperty
  a_run_read: assert property (p_run_read) else $error("run read wrong");

  property p_ctrl1_ro;
    s_ctrl1_write |=> !charge_ctrl1_o[3];
  endproperty
  a_ctrl1_ro: assert property (p_ctrl1_ro) else $error("read-only bit stored");

  property p_src;
    s_ctrl1_write |=> data_src_en_o == $past(reg_wdata_i[6]);
  endproperty
  a_src: assert property (p_src) else $error("data source enable wrong");

  property p_bias_set;
    s_det_write |=> charge_bias_en_o == $past(reg_wdata_i[0]);
  endproperty
  a_bias_set: assert property (p_bias_set) else $error("bias enable wrong");

  property p_det_read;
    s_det_read |=> reg_rdata_o[2] == $past(det_en_r) && reg_rdata_o[0] == $past(bias_r);
  endproperty
  a_det_read: assert property (p_det_read) else $error("detect read wrong");

  property p_det_result;
    s_det_read |=> reg_rdata_o[1] == $past(hi_det);
  endproperty
  a_det_result: assert property (p_det_result) else $error("detect result wrong");

  property p_det_result_off;
    !hi_current_detect_en_o |-> !hi_det;
  endproperty
  a_det_result_off: assert property (p_det_result_off) else $error("result while off");

  property p_page_write;
    s_page_write |=> acc.page == $past(reg_wdata_i[7:5]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page not stored");

  property p_page_hold;
    !(acc.wr && acc.hit_page) |=> $stable(acc.page);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page moved without write");

  property p_run_hold;
    !(acc.wr && acc.hit_run) |=> $stable(run_r);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run moved without write");

  property p_ack_pulse;
    s_strobe |=> reg_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("access not acked");

  property p_ack_idle;
    !(acc.wr || acc.rd) |=> !reg_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without access");

  property p_rdata_idle;
    !reg_ack_o |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");
endmodule // ucc_upstream_regs
`default_nettype wire

// >>> verif/ucc_soc_master.sv
`default_nettype none
module ucc_soc_master (
  // clock
  input wire logic core_clk_i,
  // register port requests
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  // register port answers
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_ack_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one byte access; speed field is only written here while no traffic runs
  // paged accesses use the page last written by the caller, or page 000 after reset
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic k);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = (a == 8'hff) ? (d & 8'he0) : d;
    reg_wr_o = w;
    reg_rd_o = ~w;
    @(negedge core_clk_i);
    q = reg_rdata_i;
    k = reg_ack_i;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines must not keep the old value
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule // ucc_soc_master
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, c1, q, d, run_v;
  logic wr, rd, ack, fs, fr, foe, dpp, dmp, hen, ben, snk, src;
  logic raw = 1'b0;
  logic vdat = 1'b0;
  logic [1:0] spd;
  logic [7:0] lf = 8'h08;
  int fail_count = 0;
  int n_compared = 0;
  wire [7:0] run_seen = {1'b0, fs, fr, foe, dpp, dmp, spd};
  always #50 core_clk_i = ~core_clk_i;
  ucc_upstream_regs ucc_upstream_regs_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .hi_current_raw_i(raw), .vdat_det_i(vdat),
    .force_suspend_o(fs), .force_reset_o(fr), .force_output_enable_o(foe),
    .dp_pulldown_en_o(dpp), .dm_pulldown_en_o(dmp), .transceiver_speed_sel_o(spd),
    .hi_current_detect_en_o(hen), .charge_bias_en_o(ben), .charge_ctrl1_o(c1),
    .data_sink_en_o(snk), .data_src_en_o(src));
  ucc_soc_master ucc_soc_master_i (.core_clk_i(core_clk_i), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .reg_ack_i(ack));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // detector result gated by its enable
  function automatic logic [7:0] exp_det(input logic [7:0] v, input logic r);
    return {5'h00, v[2], v[2] & r, v[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dd,
                     output logic [7:0] rq);
    logic k;
    ucc_soc_master_i.xfer(w, a, dd, rq, k);
    check("ack", {7'h00, k}, 8'h01);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check("run out", run_seen, 8'h00);
    acc(1'b0, 8'hff, 8'h00, q);
    check("page", q, 8'h00);
    acc(1'b0, 8'h02, 8'h00, q);
    check("page 000 run", q, 8'h00);
    acc(1'b1, 8'hff, 8'hc0, q);
    acc(1'b0, 8'hff, 8'h00, q);
    check("page", q, 8'hc0);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hff : lf;
      lf = lfsr(lf);
      acc(1'b1, 8'h02, d, q);
      check("run out", run_seen, d & 8'h7f);
      acc(1'b0, 8'h02, 8'h00, q);
      check("run read", q, d & 8'h7f);
    end
    run_v = d & 8'h7f;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : lf;
      lf = lfsr(lf);
      raw = lf[1];
      acc(1'b1, 8'h03, d, q);
      check("det out", {6'h00, hen, ben}, {6'h00, d[2], d[0]});
      acc(1'b0, 8'h03, 8'h00, q);
      check("det read", q, exp_det(d, raw));
    end
    // bias first: sink and source need its current
    acc(1'b1, 8'h03, 8'h01, q);
    check("bias", {7'h00, ben}, 8'h01);
    vdat = 1'b1;
    acc(1'b1, 8'h00, 8'h5f, q);
    check("sink src", {6'h00, snk, src}, 8'h03);
    check("ctrl1 out", c1, 8'h57);
    acc(1'b0, 8'h00, 8'h00, q);
    check("ctrl1 read", q, 8'h5f);
    acc(1'b0, 8'h10, 8'h00, q);
    check("unmapped", q, 8'h00);
    // pages 000 through 100 must leave the run and detect registers alone
    for (int j = 0; j < 5; j++) begin
      acc(1'b1, 8'hff, {j[2:0], 5'h00}, q);
      acc(1'b0, 8'hff, 8'h00, q);
      check("page", q, {j[2:0], 5'h00});
      acc(1'b1, 8'h02, ~run_v, q);
      check("run kept", run_seen, run_v);
      acc(1'b1, 8'h03, 8'hff, q);
      check("det kept", {6'h00, hen, ben}, 8'h01);
      acc(1'b0, 8'h02, 8'h00, q);
      check("unlisted read", q, 8'h00);
    end
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check("run out", run_seen, 8'h00);
    check("det out", {6'h00, hen, ben}, 8'h00);
    check("ctrl1 out", c1, 8'h00);
    acc(1'b0, 8'hff, 8'h00, q);
    check("page after reset", q, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
